/* verilog/lrc_pkg.sv */
// Purpose: Shared constants for the LED driver routing block
// Assumes: 40 MHz system clock, 8-bit register port
// Notes:   Timing tables are in microsecond ticks
package lrc_pkg;

    // Clock and tick timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register offsets
    localparam logic [7:0] OFS_CTRL        = 8'h10;
    localparam logic [7:0] OFS_STATUS      = 8'h11;
    localparam logic [7:0] OFS_PERIOD_LO   = 8'h12;
    localparam logic [7:0] OFS_PERIOD_HI   = 8'h13;
    localparam logic [7:0] OFS_PIN_FUNC    = 8'h17;
    localparam logic [7:0] OFS_MEAS_FIRST  = 8'h20;
    localparam logic [7:0] OFS_MEAS_LAST   = 8'h4E;

    // Offsets inside one measurement block
    localparam int         MEAS_COUNT      = 6;
    localparam logic [2:0] SUB_ROUTE       = 3'h0;
    localparam logic [2:0] SUB_TINT        = 3'h1;
    localparam logic [2:0] SUB_SETTLE      = 3'h3;
    localparam logic [2:0] SUB_CODE_A      = 3'h5;
    localparam logic [2:0] SUB_CODE_B      = 3'h6;

    // Field positions
    localparam int CTRL_RUN_BIT   = 0;
    localparam int CTRL_EXT_BIT   = 1;
    localparam int CTRL_CNT_LSB   = 2;
    localparam int ROUTE_SELA_LSB = 0;
    localparam int ROUTE_SELB_LSB = 2;
    localparam int ROUTE_ENA_BIT  = 4;
    localparam int ROUTE_ENB_BIT  = 5;
    localparam int ROUTE_RGE_LSB  = 6;
    localparam int TIME_SEL_LSB   = 3;
    localparam int PIN_FUNC_BIT   = 0;

    // Reset values
    localparam logic [7:0]  RST_CTRL     = 8'h00;
    localparam logic [15:0] RST_PERIOD   = 16'h03E8;
    localparam logic [7:0]  RST_MEAS     = 8'h00;

    // On-time tables in ticks, indexed by two-bit codes
    localparam logic [7:0] SETTLE_US [4] = '{8'h04, 8'h06, 8'h08, 8'h0C};
    localparam logic [7:0] TINT_US   [4] = '{8'h10, 8'h20, 8'h40, 8'h80};

    // Sequencer states
    typedef enum logic [2:0] {
        ST_SLEEP = 3'b001,
        ST_LOAD  = 3'b010,
        ST_ON    = 3'b100
    } lrc_state_t;

endpackage

/* verilog/lrc_drv_if.sv */
// Purpose: Carries one driver's routing request and resulting pin mask
// Assumes: Purely combinational path
// Notes:   One instance per current driver
`timescale 1ns/1ps
`default_nettype none
interface lrc_drv_if;
    logic [1:0] sel;
    logic       on;
    logic [3:0] pinMask;
    modport cfg (output sel, output on, input pinMask);
    modport mux (input sel, input on, output pinMask);
endinterface
`default_nettype wire

/* verilog/lrc_driver_mux.sv */
// Purpose: Four-to-one steering of one current driver
// Assumes: Select code already registered upstream
// Notes:   Disabled driver reaches no pin
`timescale 1ns/1ps
`default_nettype none
module lrc_driver_mux (
    lrc_drv_if.mux drv
);
    always_comb begin
        drv.pinMask = 4'h0;
        if (drv.on) begin
            drv.pinMask[drv.sel] = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verilog/lrc_tick_div.sv */
// Purpose: Divides the system clock into a one-cycle tick enable
// Assumes: DIV of at least 2
// Notes:   Free running so frame timing never drifts
`timescale 1ns/1ps
`default_nettype none
module lrc_tick_div #(
    parameter int DIV = 40
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    output var  logic tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic        next_tick;

    always_comb begin
        next_tick  = 1'b0;
        next_count = count + 16'h0001;
        if (count == 16'(DIV - 1)) begin
            next_count = 16'h0000;
            next_tick  = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule
`default_nettype wire

/* verilog/lrc_led_routing.sv */
// Purpose: Routes two LED current drivers onto four LED pins per measurement
// Assumes: Register strobes and trigger pin are synchronous to sys_clk
// Notes:   Outputs are registered, so pins follow the state one cycle late
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Two independent drivers each pass a four-to-one mux to reach any of the four LED pins.
// - Pin-select code 0 routes a driver to pin one, 1 to pin two, 2 to pin three, 3 to pin four.
// - Each driver takes an 8-bit current code and one of four full-scale ranges.
// - Six independent measurement blocks in registers 0x20 to 0x4E each set the routing.
// - Each measurement turns on driver A, driver B, both or neither, as its block specifies.
// - Two drivers on the same pin both drive it, so their currents add there.
// - While the shared pin is not an LED output it is the conversion trigger input.
// - Active blocks and drivers power down between frames and wake for the next frame only.
// - An enabled driver stays on for settling time plus integration time of its measurement.
module lrc_led_routing
    import lrc_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output var  logic [7:0] regRdData,
    output var  logic [1:0] ledOutPinOne,
    output var  logic [1:0] ledOutPinTwo,
    output var  logic [1:0] ledOutPinThree,
    output var  logic [1:0] ledOutPinFour,
    output var  logic       ledOutPinFourOe,
    input  wire logic       conversionTriggerIn,
    output var  logic [7:0] driverACode,
    output var  logic [7:0] driverBCode,
    output var  logic [1:0] driverFullScale,
    output var  logic       driverAOn,
    output var  logic       driverBOn,
    output var  logic       activeBlocksUp
);

    // Register storage
    logic [7:0]  ctrl;
    logic [15:0] framePeriod;
    logic        sharedPinLedSel;
    logic [7:0]  measRoute  [MEAS_COUNT];
    logic [1:0]  measTint   [MEAS_COUNT];
    logic [1:0]  measSettle [MEAS_COUNT];
    logic [7:0]  measCodeA  [MEAS_COUNT];
    logic [7:0]  measCodeB  [MEAS_COUNT];

    logic [7:0]  next_ctrl;
    logic [15:0] next_framePeriod;
    logic        next_sharedPinLedSel;
    logic [7:0]  next_measRoute  [MEAS_COUNT];
    logic [1:0]  next_measTint   [MEAS_COUNT];
    logic [1:0]  next_measSettle [MEAS_COUNT];
    logic [7:0]  next_measCodeA  [MEAS_COUNT];
    logic [7:0]  next_measCodeB  [MEAS_COUNT];
    logic [7:0]  next_regRdData;

    // Sequencer state
    lrc_state_t  state;
    lrc_state_t  next_state;
    logic [2:0]  measIdx;
    logic [2:0]  next_measIdx;
    logic [8:0]  onTimer;
    logic [8:0]  next_onTimer;
    logic [15:0] frameTimer;
    logic [15:0] next_frameTimer;
    logic        trigPrev;

    // Pin outputs
    logic [1:0]  next_pinOne;
    logic [1:0]  next_pinTwo;
    logic [1:0]  next_pinThree;
    logic [1:0]  next_pinFour;
    logic [7:0]  next_codeA;
    logic [7:0]  next_codeB;
    logic [1:0]  next_fullScale;
    logic        next_aOn;
    logic        next_bOn;

    // Block decode
    logic        tick;
    logic [7:0]  measOfs;
    logic [2:0]  accIdx;
    logic [2:0]  accSub;
    logic        measHit;
    logic        frameStart;
    logic        trigRise;
    logic [2:0]  measTotal;
    logic        ledOn;

    lrc_drv_if drvA ();
    lrc_drv_if drvB ();

    lrc_tick_div #(
        .DIV (TICK_DIV)
    ) u_tick (
        .sys_clk (sys_clk),
        .reset   (reset),
        .tick    (tick)
    );

    lrc_driver_mux u_mux_a (.drv (drvA));
    lrc_driver_mux u_mux_b (.drv (drvB));

    assign measOfs   = regAddr - OFS_MEAS_FIRST;
    assign accIdx    = measOfs[5:3];
    assign accSub    = measOfs[2:0];
    assign measHit   = (regAddr >= OFS_MEAS_FIRST) && (regAddr <= OFS_MEAS_LAST) && (accIdx < 3'(MEAS_COUNT));
    assign measTotal = ctrl[CTRL_CNT_LSB +: 3];

    // Shared pin acts as trigger only while not routed to an LED
    assign trigRise  = conversionTriggerIn && !trigPrev && !sharedPinLedSel;

    always_comb begin
        frameStart = 1'b0;
        if (ctrl[CTRL_RUN_BIT] && (state == ST_SLEEP) && (measTotal != 3'h0)) begin
            if (ctrl[CTRL_EXT_BIT]) begin
                frameStart = trigRise;
            end else begin
                frameStart = tick && (frameTimer >= framePeriod);
            end
        end
    end

    // Register write and read
    always_comb begin
        next_ctrl            = ctrl;
        next_framePeriod     = framePeriod;
        next_sharedPinLedSel = sharedPinLedSel;
        next_measRoute       = measRoute;
        next_measTint        = measTint;
        next_measSettle      = measSettle;
        next_measCodeA       = measCodeA;
        next_measCodeB       = measCodeB;
        next_regRdData       = 8'h00;
        if (regWr) begin
            unique case (regAddr)
                OFS_CTRL:      next_ctrl = {3'h0, regWrData[4:0]};
                OFS_PERIOD_LO: next_framePeriod[7:0] = regWrData;
                OFS_PERIOD_HI: next_framePeriod[15:8] = regWrData;
                OFS_PIN_FUNC:  next_sharedPinLedSel = regWrData[PIN_FUNC_BIT];
                default: begin
                    if (measHit) begin
                        unique case (accSub)
                            SUB_ROUTE:  next_measRoute[accIdx] = regWrData;
                            SUB_TINT:   next_measTint[accIdx] = regWrData[TIME_SEL_LSB +: 2];
                            SUB_SETTLE: next_measSettle[accIdx] = regWrData[TIME_SEL_LSB +: 2];
                            SUB_CODE_A: next_measCodeA[accIdx] = regWrData;
                            SUB_CODE_B: next_measCodeB[accIdx] = regWrData;
                            default: ;
                        endcase
                    end
                end
            endcase
        end
        if (regRd) begin
            unique case (regAddr)
                OFS_CTRL:      next_regRdData = ctrl;
                OFS_STATUS:    next_regRdData = {2'h0, sharedPinLedSel, conversionTriggerIn, measIdx, ledOn};
                OFS_PERIOD_LO: next_regRdData = framePeriod[7:0];
                OFS_PERIOD_HI: next_regRdData = framePeriod[15:8];
                OFS_PIN_FUNC:  next_regRdData = {7'h00, sharedPinLedSel};
                default: begin
                    if (measHit) begin
                        unique case (accSub)
                            SUB_ROUTE:  next_regRdData = measRoute[accIdx];
                            SUB_TINT:   next_regRdData = {3'h0, measTint[accIdx], 3'h0};
                            SUB_SETTLE: next_regRdData = {3'h0, measSettle[accIdx], 3'h0};
                            SUB_CODE_A: next_regRdData = measCodeA[accIdx];
                            SUB_CODE_B: next_regRdData = measCodeB[accIdx];
                            default:    next_regRdData = 8'h00;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl            <= RST_CTRL;
            framePeriod     <= RST_PERIOD;
            sharedPinLedSel <= 1'b0;
            regRdData       <= 8'h00;
            for (int i = 0; i < MEAS_COUNT; i++) begin
                measRoute[i]  <= RST_MEAS;
                measTint[i]   <= 2'h0;
                measSettle[i] <= 2'h0;
                measCodeA[i]  <= RST_MEAS;
                measCodeB[i]  <= RST_MEAS;
            end
        end else begin
            ctrl            <= next_ctrl;
            framePeriod     <= next_framePeriod;
            sharedPinLedSel <= next_sharedPinLedSel;
            regRdData       <= next_regRdData;
            measRoute       <= next_measRoute;
            measTint        <= next_measTint;
            measSettle      <= next_measSettle;
            measCodeA       <= next_measCodeA;
            measCodeB       <= next_measCodeB;
        end
    end

    // Frame sequencer
    always_comb begin
        next_state      = state;
        next_measIdx    = measIdx;
        next_onTimer    = onTimer;
        next_frameTimer = frameTimer;
        if (tick && (frameTimer != 16'hFFFF)) begin
            next_frameTimer = frameTimer + 16'h0001;
        end
        unique case (state)
            ST_SLEEP: begin
                if (frameStart) begin
                    next_state      = ST_LOAD;
                    next_measIdx    = 3'h0;
                    next_frameTimer = 16'h0000;
                end
            end
            ST_LOAD: begin
                next_onTimer = {1'b0, SETTLE_US[measSettle[measIdx]]} + {1'b0, TINT_US[measTint[measIdx]]};
                next_state   = ST_ON;
            end
            ST_ON: begin
                if (tick) begin
                    next_onTimer = onTimer - 9'h001;
                    if (onTimer == 9'h001) begin
                        // Last measurement ends the frame and powers down
                        if ((measIdx + 3'h1 >= measTotal) || (measIdx == 3'(MEAS_COUNT - 1))) begin
                            next_state = ST_SLEEP;
                        end else begin
                            next_measIdx = measIdx + 3'h1;
                            next_state   = ST_LOAD;
                        end
                    end
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state      <= ST_SLEEP;
            measIdx    <= 3'h0;
            onTimer    <= 9'h000;
            frameTimer <= 16'h0000;
            trigPrev   <= 1'b0;
        end else begin
            state      <= next_state;
            measIdx    <= next_measIdx;
            onTimer    <= next_onTimer;
            frameTimer <= next_frameTimer;
            trigPrev   <= conversionTriggerIn;
        end
    end

    // Driver routing for the running measurement
    assign ledOn = (state == ST_ON);

    assign drvA.sel = measRoute[measIdx][ROUTE_SELA_LSB +: 2];
    assign drvB.sel = measRoute[measIdx][ROUTE_SELB_LSB +: 2];
    assign drvA.on  = ledOn && measRoute[measIdx][ROUTE_ENA_BIT];
    assign drvB.on  = ledOn && measRoute[measIdx][ROUTE_ENB_BIT];

    always_comb begin
        // Both mask bits set on one pin means currents add there
        next_pinOne    = {drvB.pinMask[0], drvA.pinMask[0]};
        next_pinTwo    = {drvB.pinMask[1], drvA.pinMask[1]};
        next_pinThree  = {drvB.pinMask[2], drvA.pinMask[2]};
        // Pin four only sinks once software hands it over from trigger duty
        // Same select as the enable flop, so mask and enable never disagree
        next_pinFour   = next_sharedPinLedSel ? {drvB.pinMask[3], drvA.pinMask[3]} : 2'h0;
        next_aOn       = drvA.on;
        next_bOn       = drvB.on;
        next_codeA     = drvA.on ? measCodeA[measIdx] : 8'h00;
        next_codeB     = drvB.on ? measCodeB[measIdx] : 8'h00;
        next_fullScale = measRoute[measIdx][ROUTE_RGE_LSB +: 2];
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ledOutPinOne    <= 2'h0;
            ledOutPinTwo    <= 2'h0;
            ledOutPinThree  <= 2'h0;
            ledOutPinFour   <= 2'h0;
            ledOutPinFourOe <= 1'b0;
            driverACode     <= 8'h00;
            driverBCode     <= 8'h00;
            driverFullScale <= 2'h0;
            driverAOn       <= 1'b0;
            driverBOn       <= 1'b0;
            activeBlocksUp  <= 1'b0;
        end else begin
            ledOutPinOne    <= next_pinOne;
            ledOutPinTwo    <= next_pinTwo;
            ledOutPinThree  <= next_pinThree;
            ledOutPinFour   <= next_pinFour;
            ledOutPinFourOe <= next_sharedPinLedSel;
            driverACode     <= next_codeA;
            driverBCode     <= next_codeB;
            driverFullScale <= next_fullScale;
            driverAOn       <= next_aOn;
            driverBOn       <= next_bOn;
            // Stays up until the registered drivers have dropped
            activeBlocksUp  <= (state != ST_SLEEP) || (next_state != ST_SLEEP);
        end
    end

endmodule
`default_nettype wire

/* sim/lrc_led_routing_assertions.sv */
// Purpose: Port-level checks on the LED routing block
// Assumes: One clock domain, bound to lrc_led_routing
// Notes:   On-time bounds allow one partial tick at the start
`timescale 1ns/1ps
`default_nettype none
module lrc_routing_checker
    import lrc_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
) (
    input wire logic       sys_clk,
    input wire logic       reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdData,
    input wire logic [1:0] ledOutPinOne,
    input wire logic [1:0] ledOutPinTwo,
    input wire logic [1:0] ledOutPinThree,
    input wire logic [1:0] ledOutPinFour,
    input wire logic       ledOutPinFourOe,
    input wire logic       conversionTriggerIn,
    input wire logic [7:0] driverACode,
    input wire logic [7:0] driverBCode,
    input wire logic [1:0] driverFullScale,
    input wire logic       driverAOn,
    input wire logic       driverBOn,
    input wire logic       activeBlocksUp
);
    localparam int MAX_ON = (int'(SETTLE_US[3]) + int'(TINT_US[3])) * TICK_DIV;
    localparam int MIN_ON = (int'(SETTLE_US[0]) + int'(TINT_US[0]) - 1) * TICK_DIV + 1;
    logic        anyOn;
    logic        wrFour;
    logic        shadowSel;
    logic        next_shadowSel;
    logic [15:0] onRun;
    logic [15:0] next_onRun;
    logic [7:0]  pins;
    assign anyOn  = driverAOn | driverBOn;
    assign wrFour = regWr & (regAddr == OFS_PIN_FUNC);
    assign pins   = {ledOutPinFour, ledOutPinThree, ledOutPinTwo, ledOutPinOne};
    always_comb begin
        next_onRun     = anyOn ? onRun + 16'h0001 : 16'h0000;
        next_shadowSel = wrFour ? regWrData[PIN_FUNC_BIT] : shadowSel;
    end
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            onRun     <= 16'h0000;
            shadowSel <= 1'b0;
        end else begin
            onRun     <= next_onRun;
            shadowSel <= next_shadowSel;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    pin_four_gate_a: assert property (!ledOutPinFourOe |-> ledOutPinFour == 2'b00)
        else $error("pin four driven as trigger");
    sleep_all_off_a: assert property (!activeBlocksUp |-> !anyOn && pins == 8'h00)
        else $error("driver active between frames");
    a_off_quiet_a: assert property (!driverAOn |-> driverACode == 8'h00 && {pins[6], pins[4], pins[2], pins[0]} == 4'h0)
        else $error("idle driver A reaches a pin");
    b_off_quiet_a: assert property (!driverBOn |-> driverBCode == 8'h00 && {pins[7], pins[5], pins[3], pins[1]} == 4'h0)
        else $error("idle driver B reaches a pin");
    a_single_pin_a: assert property (driverAOn && ledOutPinFourOe |-> $onehot({pins[6], pins[4], pins[2], pins[0]}))
        else $error("driver A not on one pin");
    b_single_pin_a: assert property (driverBOn && ledOutPinFourOe |-> $onehot({pins[7], pins[5], pins[3], pins[1]}))
        else $error("driver B not on one pin");
    shared_pin_oe_a: assert property (!$past(wrFour, 1) && !$past(wrFour, 2) |-> ledOutPinFourOe == shadowSel)
        else $error("pin four enable off its select");
    on_time_max_a: assert property (anyOn |-> int'(onRun) < MAX_ON)
        else $error("driver on too long");
    on_time_min_a: assert property ($fell(anyOn) |-> int'(onRun) >= MIN_ON)
        else $error("driver on too short");
    read_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside its cycle");
    both_same_pin_c: cover property (driverAOn && driverBOn && pins[1:0] == 2'b11);
    pin_four_led_c: cover property (ledOutPinFour != 2'b00);
    frame_end_c: cover property ($fell(activeBlocksUp));
endmodule
bind lrc_led_routing lrc_routing_checker #(.TICK_DIV(TICK_DIV)) u_checker (
    .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .ledOutPinOne(ledOutPinOne), .ledOutPinTwo(ledOutPinTwo),
    .ledOutPinThree(ledOutPinThree), .ledOutPinFour(ledOutPinFour), .ledOutPinFourOe(ledOutPinFourOe),
    .conversionTriggerIn(conversionTriggerIn), .driverACode(driverACode), .driverBCode(driverBCode),
    .driverFullScale(driverFullScale), .driverAOn(driverAOn), .driverBOn(driverBOn),
    .activeBlocksUp(activeBlocksUp)
);
`default_nettype wire

/* sim/lrc_led_routing_tb_top.sv */
// Purpose: Self-checking bench for the LED routing block
// Assumes: TICK_DIV of 2 keeps frames short
// Notes:   External and internal frame starts alternate
`timescale 1ns/1ps
`default_nettype none
module lrc_led_routing_tb_top
    import lrc_pkg::*;
;
    localparam int D = 2;
    logic       sys_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic       conversionTriggerIn = 1'b0;
    logic [7:0] regRdData, driverACode, driverBCode;
    logic [1:0] ledOutPinOne, ledOutPinTwo, ledOutPinThree, ledOutPinFour, driverFullScale;
    logic       ledOutPinFourOe, driverAOn, driverBOn, activeBlocksUp;
    int         nFail = 0;
    int         checkCount = 0;
    int         seed = 70;
    int         cnt = 0;
    logic [7:0] route [6];
    logic [7:0] codeA [6];
    logic [7:0] codeB [6];
    logic [1:0] settle [6];
    logic [1:0] tint [6];

    always #12.5 sys_clk = ~sys_clk;

    lrc_led_routing #(.TICK_DIV(D)) u_dut (
        .sys_clk(sys_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .ledOutPinOne(ledOutPinOne), .ledOutPinTwo(ledOutPinTwo),
        .ledOutPinThree(ledOutPinThree), .ledOutPinFour(ledOutPinFour), .ledOutPinFourOe(ledOutPinFourOe),
        .conversionTriggerIn(conversionTriggerIn), .driverACode(driverACode), .driverBCode(driverBCode),
        .driverFullScale(driverFullScale), .driverAOn(driverAOn), .driverBOn(driverBOn),
        .activeBlocksUp(activeBlocksUp)
    );

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checkCount++;
        if (got !== exp) begin
            nFail++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chkLen(input int got, input int lo, input int hi);
        checkCount++;
        if (got < lo || got > hi) begin
            nFail++;
            $display("wrong value at %0t: on time %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        chk8(regRdData, exp, "read");
    endtask

    task automatic pulseTrigger();
        @(posedge sys_clk);
        conversionTriggerIn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        conversionTriggerIn <= 1'b0;
    endtask

    // Pin byte is {four, three, two, one}, driver A in the low bit of each pair
    function automatic logic [7:0] expPins(input logic [7:0] r, input logic fourLed);
        logic [7:0] p;
        p = 8'h00;
        if (r[4]) p[2 * r[1:0]] = 1'b1;
        if (r[5]) p[2 * r[3:2] + 1] = 1'b1;
        if (!fourLed) p[7:6] = 2'b00;
        return p;
    endfunction

    task automatic runFrame(input logic extMode, input int cnt);
        int n;
        int len;
        int ticks;
        logic [7:0] b;
        for (int i = 0; i < cnt; i++) begin
            b = 8'h20 + 8'(8 * i);
            route[i] = 8'($random(seed));
            codeA[i] = 8'($random(seed));
            codeB[i] = 8'($random(seed));
            settle[i] = 2'($random(seed));
            tint[i] = 2'($random(seed));
            // First measurement stacks both drivers on one pin
            if (i == 0) route[i][5:2] = {2'b11, route[i][1:0]};
            else if (route[i][5:4] == 2'b00) route[i][4] = 1'b1;
            wr(b, route[i]);
            wr(b + 8'h01, {3'b000, tint[i], 3'b000});
            wr(b + 8'h03, {3'b000, settle[i], 3'b000});
            wr(b + 8'h05, codeA[i]);
            wr(b + 8'h06, codeB[i]);
            rd(b, route[i]);
        end
        wr(OFS_PIN_FUNC, {7'h00, !extMode});
        wr(OFS_CTRL, {3'b000, 3'(cnt), extMode, 1'b1});
        if (extMode) pulseTrigger();
        for (int i = 0; i < cnt; i++) begin
            n = 0;
            while (driverAOn !== 1'b1 && driverBOn !== 1'b1 && n < 3000) begin
                @(negedge sys_clk);
                n++;
            end
            chk8({ledOutPinFour, ledOutPinThree, ledOutPinTwo, ledOutPinOne}, expPins(route[i], !extMode), "pins");
            chk8(driverACode, route[i][4] ? codeA[i] : 8'h00, "code A");
            chk8(driverBCode, route[i][5] ? codeB[i] : 8'h00, "code B");
            chk8({6'h00, driverFullScale}, {6'h00, route[i][7:6]}, "range");
            len = 0;
            while ((driverAOn === 1'b1 || driverBOn === 1'b1) && len < 400) begin
                @(negedge sys_clk);
                len++;
            end
            ticks = int'(SETTLE_US[settle[i]]) + int'(TINT_US[tint[i]]);
            chkLen(len, ticks * D - D + 1, ticks * D);
        end
        repeat (3) @(negedge sys_clk);
        chk8({7'h00, activeBlocksUp}, 8'h00, "awake after frame");
        // Stop internal timing before the next period can start a frame
        if (!extMode) wr(OFS_CTRL, 8'h00);
    endtask

    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", checkCount, nFail);
        if (nFail == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #(60000 * 25);
        nFail++;
        $display("wrong value at %0t: watchdog expired", $time);
        tallyAndFinish();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        rd(OFS_CTRL, RST_CTRL);
        rd(OFS_PERIOD_LO, RST_PERIOD[7:0]);
        rd(OFS_PERIOD_HI, RST_PERIOD[15:8]);
        rd(OFS_PIN_FUNC, 8'h00);
        rd(OFS_STATUS, 8'h00);
        rd(8'h4D, RST_MEAS);
        wr(8'h22, 8'hFF);
        rd(8'h22, 8'h00);
        wr(8'h4F, 8'hFF);
        rd(8'h4F, 8'h00);
        for (int k = 0; k < 4; k++) begin
            cnt = (k == 0) ? 6 : 1 + int'($unsigned($random(seed)) % 6);
            runFrame(k[0] == 1'b0, cnt);
        end
        // Trigger must be ignored while the shared pin drives an LED
        wr(OFS_PIN_FUNC, 8'h01);
        wr(OFS_CTRL, 8'h07);
        pulseTrigger();
        repeat (10) @(negedge sys_clk);
        chk8({7'h00, activeBlocksUp}, 8'h00, "frame on led pin");
        chk8({7'h00, ledOutPinFourOe}, 8'h01, "pin four enable");
        rd(OFS_PIN_FUNC, 8'h01);
        // Index is left on the last measurement of the previous frame
        rd(OFS_STATUS, {2'b00, 1'b1, 1'b0, 3'(cnt - 1), 1'b0});
        tallyAndFinish();
    end
endmodule
`default_nettype wire
